// >>> hw/sfc_map.svh
// Named constants for the supersampled frequency counter
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_ST_IDLE     3'h1
`define SFC_ST_ARMED    3'h2
`define SFC_ST_RUN      3'h4
`define SFC_STAT_BUSY   0
`define SFC_STAT_FIRST  1
`define SFC_MIN_EVENTS  2
`define SFC_ONE         1
`define SFC_DEF_SS      1
`define SFC_DEF_WIDTH   32
`endif

// >>> hw/sfc_pkg.sv
// Types shared by the supersampled frequency counter
`include "sfc_map.svh"
package sfc_pkg;
    typedef enum logic [2:0] {
        SFC_IDLE  = `SFC_ST_IDLE,
        SFC_ARMED = `SFC_ST_ARMED,
        SFC_RUN   = `SFC_ST_RUN
    } sfc_state_t;
endpackage : sfc_pkg

// >>> hw/sfc_lane_scan.sv
// Per-word trigger lane scan: event count, first and last set lane
`timescale 1ns/1ps
module sfc_lane_scan import sfc_pkg::*; #(
    parameter int SS = `SFC_DEF_SS,
    parameter int LW = 1,
    parameter int CW = 1
) (
    input  wire logic [SS-1:0] lanes,
    output logic               any_set,
    output logic [CW-1:0]      set_count,
    output logic [LW-1:0]      first_idx,
    output logic [LW-1:0]      last_idx
);
    // Lane 0 is the earliest sample of the word
    always_comb begin
        any_set   = 1'b0;
        set_count = '0;
        first_idx = '0;
        last_idx  = '0;
        for (int i = SS - 1; i >= 0; i--) begin
            if (lanes[i]) begin
                first_idx = LW'(i);
            end
        end
        for (int i = 0; i < SS; i++) begin
            if (lanes[i]) begin
                any_set   = 1'b1;
                set_count = set_count + CW'(`SFC_ONE);
                last_idx  = LW'(i);
            end
        end
    end
endmodule : sfc_lane_scan

// >>> hw/sfc_frequency_counter.sv
// Supersampled frequency counter: window control, event tally and result hold
// Notes on behaviour
// - Window clock count advances only on cycles with trigger lanes valid high.
// - Window length is a count of valid clocks, one supersampled word each.
// - Every set lane bit is one trigger event; many per clock possible.
// - Trigger lane input width equals the supersample parameter.
// - Start begins a measurement; held high, measurements follow back to back.
// - Start-on-first-edge 0 opens at start; 1 opens at first event after start.
// - Period count and elapsed samples are held from end to next end.
// - Period count is events in the window minus one, or zero with under two events.
// - Elapsed samples is first-to-last event distance in samples.
// - Status bit 0 is high while a measurement is in progress.
// - Status bit 1 is high once the first event of this measurement is seen.
// - Status 01 with start-on-first-edge means armed, awaiting first event.
// - Counter width parameter, default 32, sizes counters and value ports.
`timescale 1ns/1ps
module sfc_frequency_counter import sfc_pkg::*; #(
    parameter int SS = `SFC_DEF_SS,
    parameter int W  = `SFC_DEF_WIDTH
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic         start,
    input  wire logic         start_on_first_edge,
    input  wire logic [SS-1:0] trigger_lanes,
    input  wire logic         trigger_lanes_valid,
    input  wire logic [W-1:0] window_length,
    output logic      [W-1:0] period_count,
    output logic      [W-1:0] elapsed_samples,
    output logic      [1:0]   status,
    output logic              measure_done
);
    localparam int LW = (SS > 1) ? $clog2(SS) : 1;
    localparam int CW = $clog2(SS + 1);
    localparam logic [W-1:0] SS_W = W'(SS);

    typedef struct packed {
        sfc_state_t     st;
        logic [W-1:0]   win;
        logic [W-1:0]   ev;
        logic [W-1:0]   cur;
        logic [W-1:0]   last_pos;
        logic [LW-1:0]  first_lane;
        logic           first_seen;
        logic [W-1:0]   period;
        logic [W-1:0]   elapsed;
        logic           done;
    } sfc_regs_t;

    sfc_regs_t r_reg;
    sfc_regs_t r_next;
    logic          any_set;
    logic [CW-1:0] set_count;
    logic [LW-1:0] first_idx;
    logic [LW-1:0] last_idx;
    logic          open_win;
    logic          cap;

    // Lane scan of the current word
    sfc_lane_scan #(.SS(SS), .LW(LW), .CW(CW)) u_scan (
        .lanes     (trigger_lanes),
        .any_set   (any_set),
        .set_count (set_count),
        .first_idx (first_idx),
        .last_idx  (last_idx)
    );

    // Next-state logic
    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        open_win    = 1'b0;
        cap         = 1'b0;
        case (r_reg.st)
            SFC_IDLE: begin
                if (start) begin
                    r_next.first_seen = 1'b0;
                    r_next.win        = '0;
                    r_next.ev         = '0;
                    if (start_on_first_edge) begin
                        r_next.st = SFC_ARMED;
                    end else begin
                        r_next.st = SFC_RUN;
                        open_win  = 1'b1;
                    end
                end
            end
            SFC_ARMED: begin
                if (trigger_lanes_valid && any_set) begin
                    r_next.st = SFC_RUN;
                    open_win  = 1'b1;
                end
            end
            SFC_RUN: begin
                open_win = 1'b1;
            end
            default: begin
                r_next.st = SFC_IDLE;
            end
        endcase
        // Count one valid word of the window
        if (open_win && trigger_lanes_valid) begin
            r_next.win = r_next.win + W'(`SFC_ONE);
            r_next.ev  = r_next.ev + W'(set_count);
            if (r_next.first_seen) begin
                r_next.cur = r_next.cur + W'(`SFC_ONE);
                if (any_set) begin
                    r_next.last_pos = r_next.cur * SS_W + W'(last_idx);
                end
            end else if (any_set) begin
                r_next.first_seen = 1'b1;
                r_next.cur        = '0;
                r_next.first_lane = first_idx;
                r_next.last_pos   = W'(last_idx);
            end
            if (r_next.win >= window_length) begin
                cap         = 1'b1;
                r_next.st   = SFC_IDLE;
                r_next.done = 1'b1;
                if (r_next.ev >= W'(`SFC_MIN_EVENTS)) begin
                    r_next.period  = r_next.ev - W'(`SFC_ONE);
                    r_next.elapsed = r_next.last_pos - W'(r_next.first_lane);
                end else begin
                    r_next.period  = '0;
                    r_next.elapsed = '0;
                end
            end
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '{st: SFC_IDLE, default: '0};
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // Outputs from state flops
    assign period_count                 = r_reg.period;
    assign elapsed_samples              = r_reg.elapsed;
    assign status[`SFC_STAT_BUSY]       = (r_reg.st != SFC_IDLE);
    // First-event flag belongs to the running measurement only, so it drops at the end
    assign status[`SFC_STAT_FIRST]      = r_reg.first_seen && (r_reg.st != SFC_IDLE);
    assign measure_done                 = r_reg.done;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_window_start: assert property (
        ce && r_reg.st == SFC_IDLE && start && !start_on_first_edge && !cap |=> status[0])
        else $error("window did not open on start");
    a_armed_wait: assert property (
        ce && r_reg.st == SFC_IDLE && start && start_on_first_edge |=> status == 2'h1)
        else $error("armed status not 01");
    a_valid_gate: assert property (
        ce && r_reg.st == SFC_RUN && !trigger_lanes_valid |=> $stable(r_reg.win))
        else $error("window advanced without valid");
    a_hold_outputs: assert property (
        !cap |=> $stable(period_count) && $stable(elapsed_samples))
        else $error("results changed mid measurement");
    a_count_minus_one: assert property (
        ce && cap && r_next.ev >= W'(`SFC_MIN_EVENTS)
        |=> period_count == $past(r_next.ev) - W'(`SFC_ONE) && measure_done)
        else $error("period count not events minus one");
    a_few_events_zero: assert property (
        ce && cap && r_next.ev < W'(`SFC_MIN_EVENTS)
        |=> period_count == '0 && elapsed_samples == '0)
        else $error("results not zero with under two events");
    a_first_flag: assert property (
        ce && open_win && trigger_lanes_valid && any_set && !cap |=> status[1])
        else $error("first event flag not set");
    a_elapsed_bound: assert property (
        ce && cap && r_next.ev >= W'(`SFC_MIN_EVENTS) |=> elapsed_samples >= period_count)
        else $error("elapsed samples below period count");
    a_window_len: assert property (
        cap |-> r_next.win >= window_length
            && (r_reg.st != SFC_RUN || r_reg.win < window_length))
        else $error("window ended at wrong length");
    a_restart_held: assert property (
        ce && cap ##1 ce && start |=> status[0])
        else $error("held start did not restart");

    // Busy must be low on the cycle the results are published
    a_done_idle: assert property (
        measure_done |-> !status[0])
        else $error("busy still set at window end");

    // Every set lane of a counted word adds one event
    a_lane_tally: assert property (
        ce && r_reg.st == SFC_RUN && trigger_lanes_valid
        |=> r_reg.ev == $past(r_reg.ev) + W'($countones($past(trigger_lanes))))
        else $error("event tally not sum of set lanes");

    // Armed waits until a valid word carries an event
    a_armed_hold: assert property (
        ce && r_reg.st == SFC_ARMED && !(trigger_lanes_valid && any_set)
        |=> r_reg.st == SFC_ARMED && $stable(r_reg.win))
        else $error("window opened without a trigger event");

    // A new measurement starts its tally afresh
    a_tally_fresh: assert property (
        ce && r_reg.st == SFC_IDLE && start |=> r_reg.ev <= SS_W)
        else $error("event tally carried over into new measurement");

    // Main scenarios

    c_measure_ok: cover property (ce && cap && r_next.ev >= W'(`SFC_MIN_EVENTS));
    c_armed_run:  cover property (r_reg.st == SFC_ARMED ##1 r_reg.st == SFC_RUN);
    c_back2back:  cover property (measure_done && start ##1 status[0]);
    c_few_events: cover property (ce && cap && r_next.ev < W'(`SFC_MIN_EVENTS));
    c_gap_word:   cover property (r_reg.st == SFC_RUN && !trigger_lanes_valid);
endmodule : sfc_frequency_counter

// >>> verification/sfc_trig_model.sv
// Trigger source model: periodic events packed into supersampled words
`timescale 1ns/1ps
module sfc_trig_model import sfc_pkg::*; #(
    parameter int SS = 4
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          en,
    input  wire logic          gap,
    input  wire logic [7:0]    period,
    input  wire logic [7:0]    offset,
    output logic      [SS-1:0] trigger_lanes,
    output logic               trigger_lanes_valid
);
    logic [15:0] samp;
    logic        hole;
    // One word per clock; idle and gap words carry toggling junk lanes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            samp <= 16'h0;
            hole <= 1'b0;
            trigger_lanes <= '0;
            trigger_lanes_valid <= 1'b0;
        end else if (!en || hole) begin
            samp <= en ? samp : 16'h0;
            hole <= 1'b0;
            trigger_lanes <= ~trigger_lanes;
            trigger_lanes_valid <= 1'b0;
        end else begin
            for (int i = 0; i < SS; i++) begin
                trigger_lanes[i] <= (samp + i >= offset) &&
                                    ((samp + i - offset) % period == 0);
            end
            samp <= samp + 16'(SS);
            hole <= gap;
            trigger_lanes_valid <= 1'b1;
        end
    end
endmodule : sfc_trig_model

// >>> verification/sfc_testbench.sv
// Self-checking bench for the supersampled frequency counter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench import sfc_pkg::*;;
    typedef struct {logic sofe; logic gap; int per; int off; int len; int cnt; int el;} sfc_row_t;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic        start = 1'b0;
    logic        sofe = 1'b0;
    logic        gap = 1'b0;
    logic        en = 1'b0;
    logic [7:0]  per = 8'h1;
    logic [7:0]  off = 8'h0;
    logic [15:0] len = 16'h1;
    logic [3:0]  lanes;
    logic        lanes_valid;
    logic [15:0] period_count;
    logic [15:0] elapsed_samples;
    logic [1:0]  status;
    logic        measure_done;
    int          num_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    sfc_row_t    rows [7] = '{'{0, 0, 3, 1, 4, 4, 12}, '{0, 1, 3, 1, 4, 4, 12},
        '{0, 0, 5, 9, 3, 0, 0}, '{1, 0, 5, 9, 3, 2, 10}, '{0, 0, 2, 0, 2, 3, 6},
        '{1, 1, 4, 3, 2, 1, 4}, '{0, 0, 1, 0, 2, 7, 7}};
    sfc_frequency_counter #(.SS(4), .W(16)) i_sfc_frequency_counter (.clk(clk), .rstn(rstn),
        .ce(ce), .start(start), .start_on_first_edge(sofe), .trigger_lanes(lanes),
        .trigger_lanes_valid(lanes_valid), .window_length(len), .period_count(period_count),
        .elapsed_samples(elapsed_samples), .status(status), .measure_done(measure_done));
    sfc_trig_model #(.SS(4)) i_sfc_trig_model (.clk(clk), .rstn(rstn), .en(en), .gap(gap),
        .period(per), .offset(off), .trigger_lanes(lanes), .trigger_lanes_valid(lanes_valid));
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // Wait for the end pulse, then compare held results
    task automatic check_res(input int c, input int e);
        int n;
        n = 0;
        while (measure_done !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        `CHK("measure_done", 1'b1, measure_done)
        `CHK("period_count", 16'(c), period_count)
        `CHK("elapsed_samples", 16'(e), elapsed_samples)
        `CHK("status idle", 2'h0, status)
    endtask : check_res
    // One start pulse and a full window
    task automatic run_row(input sfc_row_t r);
        @(posedge clk);
        sofe <= r.sofe;
        gap <= r.gap;
        per <= 8'(r.per);
        off <= 8'(r.off);
        len <= 16'(r.len);
        en <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        `CHK("status armed", 2'h1, status)
        @(posedge clk);
        `CHK("status first", (r.off < 4) ? 2'h3 : 2'h1, status)
        check_res(r.cnt, r.el);
        en <= 1'b0;
    endtask : run_row
    initial begin
        repeat (20) @(posedge clk);
        `CHK("status in reset", 2'h0, status)
        rstn <= 1'b1;
        ce <= 1'b0;
        start <= 1'b1;
        en <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("status frozen", 2'h0, status)
        ce <= 1'b1;
        start <= 1'b0;
        en <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (rows[k]) begin
            run_row(rows[k]);
            $display("test %0d done", k);
        end
        // Start held high: second window follows at once
        @(posedge clk);
        per <= 8'h3;
        off <= 8'h1;
        len <= 16'h4;
        sofe <= 1'b0;
        gap <= 1'b0;
        en <= 1'b1;
        start <= 1'b1;
        check_res(4, 12);
        repeat (2) @(posedge clk);
        `CHK("held count", 16'h4, period_count)
        check_res(5, 15);
        $display("test back to back done");
        // Reset in mid-window: results and status clear, idle after release
        rstn <= 1'b0;
        @(posedge clk);
        start <= 1'b0;
        en <= 1'b0;
        @(posedge clk);
        `CHK("status mid reset", 2'h0, status)
        `CHK("count mid reset", 16'h0, period_count)
        `CHK("elapsed mid reset", 16'h0, elapsed_samples)
        `CHK("done mid reset", 1'b0, measure_done)
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("status after reset", 2'h0, status)
        $display("test mid reset done");
        finish_test();
    end
endmodule : testbench
